// ===== bench/lcw_host_model.sv
// host model that writes command bytes and drives data read/write strobes to the decoder
`timescale 1ns/100ps
module lcw_host_model (
   // clock
   input  wire logic       sys_clk,
   // host strobes
   output logic            cmd_valid,
   output logic [7:0]      cmd_byte,
   output logic            data_write,
   output logic            data_read
);
   initial begin
      cmd_valid  = 1'b0;
      cmd_byte   = 8'h00;
      data_write = 1'b0;
      data_read  = 1'b0;
   end
   // byte held one full cycle, then inverted so a stale value never matches
   task automatic put_cmd(input logic [7:0] b);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_byte  = b;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      cmd_byte  = ~b;
   endtask : put_cmd
   // contrast opcode always followed by its level byte
   task automatic put_contrast(input logic [7:0] lvl);
      put_cmd(8'h81);
      put_cmd(lvl);
   endtask : put_contrast
   task automatic put_data(input logic rd);
      @(negedge sys_clk);
      data_read  = rd;
      data_write = ~rd;
      @(negedge sys_clk);
      data_read  = 1'b0;
      data_write = 1'b0;
   endtask : put_data
endmodule : lcw_host_model

// ===== bench/tb_lcd_write_command_decoder.sv
// self-checking bench for the write command decoder
`timescale 1ns/100ps
module tb_lcd_write_command_decoder;
   import lcw_pkg::*;
   logic       sys_clk, arst_n, cmd_valid, data_write, data_read;
   logic [7:0] cmd_byte, column_q;
   logic [3:0] page_q;
   logic [5:0] start_line_q, contrast_q;
   logic [2:0] reg_gain_q, power_en_q;
   logic       seg_remap_q, com_reverse_q, display_on_q;
   logic       entire_on_q, inverse_q, rmw_mode_q;
   int         miscompares = 0;
   int         samples_checked = 0;
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   lcw_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .data_write(data_write), .data_read(data_read));
   lcw_decoder uut (.sys_clk(sys_clk), .arst_n(arst_n),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .data_write(data_write),
      .data_read(data_read), .column_q(column_q), .page_q(page_q),
      .start_line_q(start_line_q), .contrast_q(contrast_q),
      .reg_gain_q(reg_gain_q), .power_en_q(power_en_q),
      .seg_remap_q(seg_remap_q), .com_reverse_q(com_reverse_q),
      .display_on_q(display_on_q), .entire_on_q(entire_on_q),
      .inverse_q(inverse_q), .rmw_mode_q(rmw_mode_q));
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // extra cycle lets the registered answer land before it is sampled
   task automatic cmd(input logic [7:0] b);
      host.put_cmd(b);
      @(negedge sys_clk);
   endtask : cmd
   task automatic access(input logic rd);
      host.put_data(rd);
      @(negedge sys_clk);
   endtask : access
   task automatic chk_reset;
      chk("column", {LCW_COL_NIB_RST, LCW_COL_NIB_RST}, column_q);
      chk("gain", {5'h00, LCW_GAIN_RST}, {5'h00, reg_gain_q});
      chk("power", {5'h00, LCW_PWR_RST}, {5'h00, power_en_q});
      chk("start", {2'h0, LCW_START_RST}, {2'h0, start_line_q});
      chk("contrast", {2'h0, LCW_CONTRAST_RST}, {2'h0, contrast_q});
      chk("page", {4'h0, LCW_PAGE_RST}, {4'h0, page_q});
      chk("seg", 8'h00, {7'h00, seg_remap_q});
      chk("entire", 8'h00, {7'h00, entire_on_q});
      chk("display", 8'h00, {7'h00, display_on_q});
      chk("com", 8'h00, {7'h00, com_reverse_q});
      chk("rmw", 8'h00, {7'h00, rmw_mode_q});
      chk("inverse", 8'h00, {7'h00, inverse_q});
   endtask : chk_reset
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   // whole run is about 120 cycles; this limit leaves a wide margin
   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end
   initial begin
      arst_n = 1'b0;
      repeat (20) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk_reset();
      $display("test reset_values done");
      cmd(8'h0A);
      cmd(8'h17);
      chk("column", 8'h7A, column_q);
      cmd(8'h18);
      chk("column", 8'h8A, column_q);
      cmd(8'h00);
      access(1'b1);
      chk("column", 8'h81, column_q);
      cmd(8'h02);
      access(1'b0);
      chk("column", 8'h83, column_q);
      access(1'b0);
      chk("column", 8'h83, column_q);
      $display("test column_pointer done");
      cmd(8'h27);
      chk("gain", 8'h07, {5'h00, reg_gain_q});
      cmd(8'h2D);
      chk("power", 8'h05, {5'h00, power_en_q});
      cmd(8'h2A);
      chk("power", 8'h02, {5'h00, power_en_q});
      cmd(8'h7F);
      chk("start", 8'h3F, {2'h0, start_line_q});
      host.put_contrast(8'hE2);
      @(negedge sys_clk);
      chk("contrast", 8'h22, {2'h0, contrast_q});
      chk("gain", 8'h07, {5'h00, reg_gain_q});
      cmd(8'hA1);
      chk("seg", 8'h01, {7'h00, seg_remap_q});
      cmd(8'hA5);
      chk("entire", 8'h01, {7'h00, entire_on_q});
      cmd(8'hA4);
      chk("entire", 8'h00, {7'h00, entire_on_q});
      cmd(8'hAF);
      chk("display", 8'h01, {7'h00, display_on_q});
      cmd(8'hAE);
      chk("display", 8'h00, {7'h00, display_on_q});
      cmd(8'hAF);
      chk("display", 8'h01, {7'h00, display_on_q});
      cmd(8'hB8);
      chk("page", 8'h08, {4'h0, page_q});
      cmd(8'hC8);
      chk("com", 8'h01, {7'h00, com_reverse_q});
      cmd(8'hA7);
      chk("inverse", 8'h01, {7'h00, inverse_q});
      $display("test config_commands done");
      cmd(8'h13);
      cmd(8'h04);
      cmd(LCW_OP_RMW_ON);
      chk("rmw", 8'h01, {7'h00, rmw_mode_q});
      access(1'b1);
      chk("column", 8'h34, column_q);
      access(1'b0);
      cmd(LCW_OP_RMW_ON);
      access(1'b0);
      chk("column", 8'h36, column_q);
      cmd(LCW_OP_RMW_OFF);
      chk("column", 8'h34, column_q);
      chk("rmw", 8'h00, {7'h00, rmw_mode_q});
      $display("test read_modify_write done");
      cmd(LCW_OP_SOFT_RST);
      chk_reset();
      $display("test soft_reset done");
      wrap_up();
   end
endmodule : tb_lcd_write_command_decoder

// ===== design/lcw_col_ptr.sv
// column address pointer with auto increment and rmw save/restore
`timescale 1ns/100ps
module lcw_col_ptr
   import lcw_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // controls
   input  wire logic       clear,
   input  wire logic       load_lo,
   input  wire logic       load_hi,
   input  wire logic [3:0] nibble,
   input  wire logic       incr,
   input  wire logic       save,
   input  wire logic       restore,
   // pointer
   output logic [7:0]      col_q
);
   logic [7:0] col_d;
   logic [7:0] saved_q;
   logic [7:0] saved_d;

   always_comb begin
      col_d   = col_q;
      saved_d = saved_q;
      if (clear) begin
         col_d   = {LCW_COL_NIB_RST, LCW_COL_NIB_RST};
         saved_d = {LCW_COL_NIB_RST, LCW_COL_NIB_RST};
      end else if (load_lo) begin
         col_d = {col_q[7:4], nibble};
      end else if (load_hi) begin
         col_d = {nibble, col_q[3:0]};
      end else if (restore) begin
         col_d = saved_q;
      end else if (incr && col_q < LCW_COL_MAX) begin
         col_d = col_q + 8'h01;
      end
      // save may share the cycle with a pointer change; only clear blocks it
      if (save && !clear) begin
         saved_d = col_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         col_q   <= {LCW_COL_NIB_RST, LCW_COL_NIB_RST};
         saved_q <= {LCW_COL_NIB_RST, LCW_COL_NIB_RST};
      end else begin
         col_q   <= col_d;
         saved_q <= saved_d;
      end
   end

   a_col_saturate: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (col_q == LCW_COL_MAX && incr && !clear && !load_lo && !load_hi
       && !restore) |=> col_q == LCW_COL_MAX)
      else $error("column pointer passed its last column");
   a_col_step: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (col_q < LCW_COL_MAX && incr && !clear && !load_lo && !load_hi
       && !restore) |=> col_q == $past(col_q) + 8'h01)
      else $error("column pointer did not step by one");
   a_col_lo_only: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (load_lo && !clear) |=> col_q[7:4] == $past(col_q[7:4])
      && col_q[3:0] == $past(nibble))
      else $error("lower nibble load disturbed upper nibble");
   a_col_hi_only: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (load_hi && !clear && !load_lo) |=> col_q[3:0] == $past(col_q[3:0])
      && col_q[7:4] == $past(nibble))
      else $error("upper nibble load disturbed lower nibble");
endmodule : lcw_col_ptr

// ===== design/lcw_decoder.sv
// write command decoder holding the controller's control state
// Behaviour
// - low column command loads lower pointer nibble
// - high column command loads upper pointer nibble
// - three-bit regulator gain, resets to 100b
// - power bits: buffer, regulator, booster; off
// - top bits 01 load six-bit start line
// - contrast opcode then six-bit level, reset 20h
// - segment remap bit reverses column order
// - entire display bit forces all pixels on
// - display on/off bit, off after reset
// - page command loads four-bit page pointer
// - common scan direction bit, normal after reset
// - opcode E0h enters read-modify-write mode
// - opcode E2h resets all configuration state
// - opcode EEh leaves mode, restores column
// - data write, or read outside rmw mode, increments column, saturates 131
`timescale 1ns/100ps
module lcw_decoder
   import lcw_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   // host byte strobes, already in the sys_clk domain
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_byte,
   input  wire logic       data_write,
   input  wire logic       data_read,
   // control state
   output logic [7:0]      column_q,
   output logic [3:0]      page_q,
   output logic [5:0]      start_line_q,
   output logic [5:0]      contrast_q,
   output logic [2:0]      reg_gain_q,
   output logic [2:0]      power_en_q,
   output logic            seg_remap_q,
   output logic            com_reverse_q,
   output logic            display_on_q,
   output logic            entire_on_q,
   output logic            inverse_q,
   output logic            rmw_mode_q
);
   logic [1:0] rst_sync_q;
   logic       rst_n;
   lcw_opc_t   opc_q;
   lcw_opc_t   opc_d;
   logic [3:0] page_d;
   logic [5:0] start_line_d;
   logic [5:0] contrast_d;
   logic [2:0] reg_gain_d;
   logic [2:0] power_en_d;
   logic       seg_remap_d;
   logic       com_reverse_d;
   logic       display_on_d;
   logic       entire_on_d;
   logic       inverse_d;
   logic       rmw_mode_d;
   logic       soft_rst;
   logic       is_cmd;
   logic       col_incr;

   // reset released through two flops so release is clean to sys_clk
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // second byte of the contrast command is not an opcode
   assign is_cmd   = cmd_valid && opc_q == LCW_OPC_IDLE;
   assign soft_rst = is_cmd && cmd_byte == LCW_OP_SOFT_RST;
   // reads in rmw mode leave the pointer alone
   assign col_incr = data_write || (data_read && !rmw_mode_q);

   always_comb begin
      opc_d         = opc_q;
      page_d        = page_q;
      start_line_d  = start_line_q;
      contrast_d    = contrast_q;
      reg_gain_d    = reg_gain_q;
      power_en_d    = power_en_q;
      seg_remap_d   = seg_remap_q;
      com_reverse_d = com_reverse_q;
      display_on_d  = display_on_q;
      entire_on_d   = entire_on_q;
      inverse_d     = inverse_q;
      rmw_mode_d    = rmw_mode_q;
      case (opc_q)
         LCW_OPC_CONTRAST: begin
            if (cmd_valid) begin
               contrast_d = cmd_byte[5:0];
               opc_d      = LCW_OPC_IDLE;
            end
         end
         LCW_OPC_IDLE: begin
            if (cmd_valid) begin
               if (cmd_byte[7:6] == 2'b01) begin
                  start_line_d = cmd_byte[5:0];
               end else if (cmd_byte == LCW_OP_CONTRAST) begin
                  opc_d = LCW_OPC_CONTRAST;
               end else if (cmd_byte[7:3] == 5'b00100) begin
                  reg_gain_d = cmd_byte[2:0];
               end else if (cmd_byte[7:3] == 5'b00101) begin
                  power_en_d = cmd_byte[2:0];
               end else if (cmd_byte[7:1] == 7'b1010000) begin
                  seg_remap_d = cmd_byte[0];
               end else if (cmd_byte[7:1] == 7'b1010010) begin
                  entire_on_d = cmd_byte[0];
               end else if (cmd_byte[7:1] == 7'b1010011) begin
                  inverse_d = cmd_byte[0];
               end else if (cmd_byte[7:1] == 7'b1010111) begin
                  display_on_d = cmd_byte[0];
               end else if (cmd_byte[7:4] == 4'b1011) begin
                  page_d = cmd_byte[3:0];
               end else if (cmd_byte[7:4] == 4'b1100) begin
                  com_reverse_d = cmd_byte[3];
               end else if (cmd_byte == LCW_OP_RMW_ON) begin
                  rmw_mode_d = 1'b1;
               end else if (cmd_byte == LCW_OP_RMW_OFF) begin
                  rmw_mode_d = 1'b0;
               end
            end
         end
         default: begin
            opc_d = LCW_OPC_IDLE;
         end
      endcase
      if (soft_rst) begin
         opc_d         = LCW_OPC_IDLE;
         page_d        = LCW_PAGE_RST;
         start_line_d  = LCW_START_RST;
         contrast_d    = LCW_CONTRAST_RST;
         reg_gain_d    = LCW_GAIN_RST;
         power_en_d    = LCW_PWR_RST;
         seg_remap_d   = 1'b0;
         com_reverse_d = 1'b0;
         display_on_d  = 1'b0;
         entire_on_d   = 1'b0;
         inverse_d     = 1'b0;
         rmw_mode_d    = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         opc_q         <= LCW_OPC_IDLE;
         page_q        <= LCW_PAGE_RST;
         start_line_q  <= LCW_START_RST;
         contrast_q    <= LCW_CONTRAST_RST;
         reg_gain_q    <= LCW_GAIN_RST;
         power_en_q    <= LCW_PWR_RST;
         seg_remap_q   <= 1'b0;
         com_reverse_q <= 1'b0;
         display_on_q  <= 1'b0;
         entire_on_q   <= 1'b0;
         inverse_q     <= 1'b0;
         rmw_mode_q    <= 1'b0;
      end else begin
         opc_q         <= opc_d;
         page_q        <= page_d;
         start_line_q  <= start_line_d;
         contrast_q    <= contrast_d;
         reg_gain_q    <= reg_gain_d;
         power_en_q    <= power_en_d;
         seg_remap_q   <= seg_remap_d;
         com_reverse_q <= com_reverse_d;
         display_on_q  <= display_on_d;
         entire_on_q   <= entire_on_d;
         inverse_q     <= inverse_d;
         rmw_mode_q    <= rmw_mode_d;
      end
   end

   lcw_col_ptr u_col (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clear   (soft_rst),
      .load_lo (is_cmd && cmd_byte[7:4] == 4'b0000),
      .load_hi (is_cmd && cmd_byte[7:4] == 4'b0001),
      .nibble  (cmd_byte[3:0]),
      .incr    (col_incr),
      .save    (is_cmd && cmd_byte == LCW_OP_RMW_ON && !rmw_mode_q),
      .restore (is_cmd && cmd_byte == LCW_OP_RMW_OFF && rmw_mode_q),
      .col_q   (column_q)
   );

   a_start_load: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (is_cmd && cmd_byte[7:6] == 2'b01)
      |=> start_line_q == $past(cmd_byte[5:0]))
      else $error("start line not loaded");
   a_contrast_arm: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (is_cmd && cmd_byte == LCW_OP_CONTRAST)
      |=> opc_q == LCW_OPC_CONTRAST)
      else $error("contrast opcode did not wait for its level");
   a_contrast_two: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (opc_q == LCW_OPC_CONTRAST && cmd_valid)
      |=> contrast_q == $past(cmd_byte[5:0]) && opc_q == LCW_OPC_IDLE)
      else $error("contrast second byte not taken");
   a_gain_load: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (is_cmd && cmd_byte[7:3] == 5'b00100)
      |=> reg_gain_q == $past(cmd_byte[2:0]))
      else $error("regulator gain not loaded");
   a_power_load: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (is_cmd && cmd_byte[7:3] == 5'b00101)
      |=> power_en_q == $past(cmd_byte[2:0]))
      else $error("power enables not loaded");
   a_soft_reset: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      soft_rst |=> contrast_q == LCW_CONTRAST_RST && reg_gain_q == LCW_GAIN_RST
      && !display_on_q && !rmw_mode_q
      && column_q == {LCW_COL_NIB_RST, LCW_COL_NIB_RST})
      else $error("software reset left state behind");
   a_rmw_hold: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (rmw_mode_q && data_read && !data_write && !cmd_valid)
      |=> $stable(column_q))
      else $error("column moved on read in rmw mode");
   // exit may come many accesses after entry, so check against the saved copy
   a_rmw_restore: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (is_cmd && cmd_byte == LCW_OP_RMW_OFF && rmw_mode_q)
      |=> column_q == $past(u_col.saved_q) && !rmw_mode_q)
      else $error("column not restored on rmw exit");
   a_display_bit: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (is_cmd && cmd_byte[7:1] == 7'b1010111)
      |=> display_on_q == $past(cmd_byte[0]))
      else $error("display on/off not taken");
endmodule : lcw_decoder

// ===== design/lcw_pkg.sv
// constants for the lcd write command decoder
package lcw_pkg;
   localparam logic [3:0] LCW_COL_NIB_RST   = 4'h0;
   localparam logic [2:0] LCW_GAIN_RST      = 3'h4;
   localparam logic [2:0] LCW_PWR_RST       = 3'h0;
   localparam logic [5:0] LCW_START_RST     = 6'h00;
   localparam logic [5:0] LCW_CONTRAST_RST  = 6'h20;
   localparam logic [3:0] LCW_PAGE_RST      = 4'h0;
   localparam logic [7:0] LCW_COL_MAX       = 8'h83;
   localparam logic [7:0] LCW_OP_CONTRAST   = 8'h81;
   localparam logic [7:0] LCW_OP_RMW_ON     = 8'hE0;
   localparam logic [7:0] LCW_OP_RMW_OFF    = 8'hEE;
   localparam logic [7:0] LCW_OP_SOFT_RST   = 8'hE2;
   localparam int         LCW_PWR_BUF_BIT   = 0;
   localparam int         LCW_PWR_REG_BIT   = 1;
   localparam int         LCW_PWR_BOOST_BIT = 2;
   typedef enum logic [1:0] {
      LCW_OPC_IDLE,
      LCW_OPC_CONTRAST
   } lcw_opc_t;
endpackage : lcw_pkg
